// ### anpr_consts.svh
// register offsets, field positions and reset values of the next-page registers
`ifndef ANPR_CONSTS_SVH
`define ANPR_CONSTS_SVH

`define ANPR_REG_PARTNER    5'h05
`define ANPR_REG_EXPANSION  5'h06
`define ANPR_REG_TRANSMIT   5'h07

`define ANPR_BIT_MORE       15
`define ANPR_BIT_CONFIRM    14
`define ANPR_BIT_FORMATTED  13
`define ANPR_BIT_COMPLY     12
`define ANPR_BIT_SYNC       11
`define ANPR_CODE_MSB       10
`define ANPR_CODE_W         11

`define ANPR_EXP_FAULT      4
`define ANPR_EXP_PARTNER_NP 3
`define ANPR_EXP_LOCAL_NP   2
`define ANPR_EXP_ARRIVED    1
`define ANPR_EXP_PARTNER_AN 0

`define ANPR_WORD_RST       16'h0000
`define ANPR_RO_TX_MASK     16'h4800
`define ANPR_EXP_PAD        11'h000

`endif

// ### anpr_pkg.sv
// types shared by the next-page register bank
package anpr_pkg;
    typedef logic [4:0]  anpr_addr_t;
    typedef logic [15:0] anpr_word_t;

    typedef struct packed {
        anpr_word_t partner_word;
        anpr_word_t tx_word;
        logic       tx_pending;
        anpr_word_t rdata;
        logic       rvalid;
    } anpr_state_t;

    typedef struct packed {
        logic flag;
    } anpr_flag_state_t;
endpackage : anpr_pkg

// ### anpr_sticky_flag.sv
// latched-high status flag, cleared by a status read
`timescale 1ns/1ns
module anpr_sticky_flag (
    // clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    // event and clear
    input  wire logic set_i,
    input  wire logic clr_i,
    // flag
    output logic      flag_o
);
    import anpr_pkg::*;

    anpr_flag_state_t s_ff;
    anpr_flag_state_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        // set beats clear so an event during the read is kept
        if (set_i) begin
            nxt_s.flag = 1'b1;
        end else if (clr_i) begin
            nxt_s.flag = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign flag_o = s_ff.flag;
endmodule : anpr_sticky_flag

// ### anpr_regs.sv
// next-page partner, expansion and transmit registers of one port
`timescale 1ns/1ns
`include "anpr_consts.svh"
module anpr_regs #(
    parameter int TECH_N = 3
) (
    // clock and reset
    input  wire logic               sys_clk_i,
    input  wire logic               rst_i,
    // management register access
    input  wire anpr_pkg::anpr_addr_t mgmt_addr_i,
    input  wire logic               mgmt_wr_i,
    input  wire logic               mgmt_rd_i,
    input  wire anpr_pkg::anpr_word_t mgmt_wdata_i,
    output anpr_pkg::anpr_word_t    mgmt_rdata_o,
    output logic                    mgmt_rvalid_o,
    // arbitration function, received pages and status
    input  wire logic               rx_page_valid_i,
    input  wire anpr_pkg::anpr_word_t rx_page_word_i,
    input  wire logic [TECH_N-1:0]  tech_link_i,
    input  wire logic               partner_extra_page_support_i,
    input  wire logic               partner_negotiation_capable_i,
    input  wire logic               link_ack_i,
    // arbitration function, transmit side
    input  wire logic               base_page_done_i,
    input  wire logic               base_bit11_i,
    input  wire logic               tx_page_sent_i,
    output anpr_pkg::anpr_word_t    tx_page_word_o,
    output logic                    tx_page_ready_o,
    // latched status
    output logic                    multi_technology_link_fault_o,
    output logic                    page_arrived_flag_o
);
    import anpr_pkg::*;

    // fault detection needs at least two technologies to compare
    if (TECH_N < 2) begin : g_tech_check
        $error("TECH_N must be at least 2");
    end

    // true when two or more technologies see link at once
    function automatic logic multi_link(input logic [TECH_N-1:0] v);
        int n;
        n = 0;
        for (int i = 0; i < TECH_N; i++) begin
            n = n + int'(v[i]);
        end
        return n > 1;
    endfunction : multi_link

    anpr_state_t s_ff;
    anpr_state_t nxt_s;
    logic        fault_q;
    logic        arrived_q;
    logic        exp_read;
    logic        fault_set;

    assign exp_read  = mgmt_rd_i && (mgmt_addr_i == `ANPR_REG_EXPANSION);
    assign fault_set = multi_link(tech_link_i);

    anpr_sticky_flag u_fault (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .set_i     (fault_set),
        .clr_i     (exp_read),
        .flag_o    (fault_q)
    );

    anpr_sticky_flag u_arrived (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .set_i     (rx_page_valid_i),
        .clr_i     (exp_read),
        .flag_o    (arrived_q)
    );

    always_comb begin
        nxt_s = s_ff;
        nxt_s.rvalid = mgmt_rd_i;
        // whole received word kept, field positions as the partner sent
        if (rx_page_valid_i) begin
            nxt_s.partner_word = rx_page_word_i;
        end
        // partner sync bit is read straight from its word
        // software fields only; confirm and sync bits are not writable
        if (mgmt_wr_i && mgmt_addr_i == `ANPR_REG_TRANSMIT) begin
            nxt_s.tx_word = (mgmt_wdata_i & ~`ANPR_RO_TX_MASK)
                          | (s_ff.tx_word & `ANPR_RO_TX_MASK);
        end
        nxt_s.tx_word[`ANPR_BIT_CONFIRM] = link_ack_i;
        if (base_page_done_i) begin
            nxt_s.tx_word[`ANPR_BIT_SYNC] = ~base_bit11_i;
        end else if (tx_page_sent_i) begin
            nxt_s.tx_word[`ANPR_BIT_SYNC] =
                ~s_ff.tx_word[`ANPR_BIT_SYNC];
        end
        // a write in the sent cycle is a fresh page, so it stays pending
        if (mgmt_wr_i && mgmt_addr_i == `ANPR_REG_TRANSMIT) begin
            nxt_s.tx_pending = 1'b1;
        end else if (tx_page_sent_i) begin
            nxt_s.tx_pending = 1'b0;
        end
        nxt_s.rdata = `ANPR_WORD_RST;
        if (mgmt_rd_i) begin
            case (mgmt_addr_i)
                `ANPR_REG_PARTNER: begin
                    nxt_s.rdata = s_ff.partner_word;
                end
                `ANPR_REG_EXPANSION: begin
                    nxt_s.rdata = {`ANPR_EXP_PAD,
                                   fault_q,
                                   partner_extra_page_support_i,
                                   1'b1,
                                   arrived_q,
                                   partner_negotiation_capable_i};
                end
                `ANPR_REG_TRANSMIT: begin
                    nxt_s.rdata = s_ff.tx_word;
                end
                default: begin
                    nxt_s.rdata = `ANPR_WORD_RST;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign mgmt_rdata_o                  = s_ff.rdata;
    assign mgmt_rvalid_o                 = s_ff.rvalid;
    assign tx_page_word_o                = s_ff.tx_word;
    assign tx_page_ready_o               = s_ff.tx_pending;
    assign multi_technology_link_fault_o = fault_q;
    assign page_arrived_flag_o           = arrived_q;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_exp_read;
        mgmt_rd_i && mgmt_addr_i == `ANPR_REG_EXPANSION;
    endsequence

    sequence s_tx_write;
        mgmt_wr_i && mgmt_addr_i == `ANPR_REG_TRANSMIT;
    endsequence

    property p_rx_more;
        rx_page_valid_i |=> s_ff.partner_word[`ANPR_BIT_MORE]
            == $past(rx_page_word_i[`ANPR_BIT_MORE]);
    endproperty
    a_rx_more: assert property (p_rx_more)
        else $error("partner more-pages bit wrong");

    sequence s_partner_read;
        mgmt_rd_i && mgmt_addr_i == `ANPR_REG_PARTNER && !rx_page_valid_i;
    endsequence

    // a quiet cycle between arrival and read, as software sees it
    property p_rx_confirm;
        rx_page_valid_i ##1 !rx_page_valid_i ##1 s_partner_read |=>
            mgmt_rdata_o[`ANPR_BIT_CONFIRM]
            == $past(rx_page_word_i[`ANPR_BIT_CONFIRM], 3);
    endproperty
    a_rx_confirm: assert property (p_rx_confirm)
        else $error("partner confirm bit not reported");

    property p_rx_code;
        rx_page_valid_i |=> s_ff.partner_word[`ANPR_CODE_MSB:0]
            == $past(rx_page_word_i[`ANPR_CODE_MSB:0]);
    endproperty
    a_rx_code: assert property (p_rx_code)
        else $error("partner code field wrong");

    // second cycle may legally clear if software read right after the set
    property p_fault_set;
        fault_set |=> multi_technology_link_fault_o
            ##1 (multi_technology_link_fault_o || $past(exp_read));
    endproperty
    a_fault_set: assert property (p_fault_set)
        else $error("fault flag not latched");

    property p_fault_hold;
        multi_technology_link_fault_o && !mgmt_rd_i |=>
            multi_technology_link_fault_o;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault flag cleared without read");

    property p_local_np;
        s_exp_read |=> mgmt_rvalid_o && mgmt_rdata_o[`ANPR_EXP_LOCAL_NP];
    endproperty
    a_local_np: assert property (p_local_np)
        else $error("local extra-page bit not one");

    property p_arrived_clear;
        s_exp_read and !rx_page_valid_i |=> !page_arrived_flag_o;
    endproperty
    a_arrived_clear: assert property (p_arrived_clear)
        else $error("page arrived flag not cleared by read");

    property p_ack;
        ##1 tx_page_word_o[`ANPR_BIT_CONFIRM] == $past(link_ack_i);
    endproperty
    a_ack: assert property (p_ack)
        else $error("transmit confirm does not follow ack");

    property p_sync_first;
        base_page_done_i |=> tx_page_word_o[`ANPR_BIT_SYNC]
            != $past(base_bit11_i);
    endproperty
    a_sync_first: assert property (p_sync_first)
        else $error("first sync bit not inverted");

    property p_sync_flip;
        tx_page_sent_i && !base_page_done_i |=>
            $changed(tx_page_word_o[`ANPR_BIT_SYNC]);
    endproperty
    a_sync_flip: assert property (p_sync_flip)
        else $error("sync bit did not alternate");

    property p_tx_offer;
        s_tx_write |=> tx_page_ready_o && tx_page_word_o[`ANPR_BIT_MORE]
            == $past(mgmt_wdata_i[`ANPR_BIT_MORE]);
    endproperty
    a_tx_offer: assert property (p_tx_offer)
        else $error("written page not offered");
endmodule : anpr_regs

// ### anpr_link_partner.sv
// link partner and arbitration model driving the link side of the bank
`timescale 1ns/1ns
module anpr_link_partner (
    // clock
    input  wire logic           sys_clk_i,
    // link side towards the bank
    output anpr_pkg::anpr_word_t rx_word_o,
    output logic                rx_valid_o,
    output logic [2:0]          tech_o,
    output logic                np_o,
    output logic                an_o,
    output logic                ack_o,
    output logic                base_done_o,
    output logic                base_b11_o,
    output logic                sent_o
);
    import anpr_pkg::*;

    initial begin
        {rx_word_o, rx_valid_o, tech_o, np_o, an_o} = '0;
        {ack_o, base_done_o, base_b11_o, sent_o} = '0;
    end

    // page word kept whole in 16 bits
    task automatic send_page(input anpr_word_t w);
        @(negedge sys_clk_i);
        rx_word_o  = w;
        rx_valid_o = 1'b1;
        @(negedge sys_clk_i);
        rx_valid_o = 1'b0;
        // stale word must not look valid
        rx_word_o  = ~w;
    endtask : send_page

    task automatic base_done(input logic b11);
        @(negedge sys_clk_i);
        base_b11_o  = b11;
        base_done_o = 1'b1;
        @(negedge sys_clk_i);
        base_done_o = 1'b0;
        base_b11_o  = ~b11;
    endtask : base_done

    task automatic page_sent;
        @(negedge sys_clk_i);
        sent_o = 1'b1;
        @(negedge sys_clk_i);
        sent_o = 1'b0;
    endtask : page_sent

    task automatic tech_burst(input logic [2:0] t);
        @(negedge sys_clk_i);
        tech_o = t;
        @(negedge sys_clk_i);
        tech_o = 3'h0;
    endtask : tech_burst

    task automatic levels(input logic np, input logic an, input logic ack);
        @(negedge sys_clk_i);
        {np_o, an_o, ack_o} = {np, an, ack};
    endtask : levels
endmodule : anpr_link_partner

// ### anpr_regs_test.sv
// self-checking bench for the next-page register bank
`timescale 1ns/1ns
`include "anpr_consts.svh"
module anpr_regs_test;
    import anpr_pkg::*;
    logic       sys_clk_i = 1'b0;
    logic       rst_i = 1'b1;
    anpr_addr_t addr = '0;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    anpr_word_t wdata = '0;
    anpr_word_t rdata, rx_word, tx_word;
    logic       rvalid, rx_valid, np, an, ack, bdone, b11, sent;
    logic       ready, fault, arrived;
    logic [2:0] tech;
    int         n_errors = 0;
    int         total_checks = 0;
    int         cycles = 0;
    anpr_word_t pages [7] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000,
                              16'h0800, 16'h07ff, 16'ha5a5};

    always #5 sys_clk_i = ~sys_clk_i;

    anpr_link_partner lp (.sys_clk_i(sys_clk_i), .rx_word_o(rx_word),
        .rx_valid_o(rx_valid), .tech_o(tech), .np_o(np), .an_o(an),
        .ack_o(ack), .base_done_o(bdone), .base_b11_o(b11),
        .sent_o(sent));

    anpr_regs dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
        .mgmt_addr_i(addr), .mgmt_wr_i(wr), .mgmt_rd_i(rd),
        .mgmt_wdata_i(wdata), .mgmt_rdata_o(rdata),
        .mgmt_rvalid_o(rvalid), .rx_page_valid_i(rx_valid),
        .rx_page_word_i(rx_word), .tech_link_i(tech),
        .partner_extra_page_support_i(np),
        .partner_negotiation_capable_i(an), .link_ack_i(ack),
        .base_page_done_i(bdone), .base_bit11_i(b11),
        .tx_page_sent_i(sent), .tx_page_word_o(tx_word),
        .tx_page_ready_o(ready), .multi_technology_link_fault_o(fault),
        .page_arrived_flag_o(arrived));

    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    // bounded run: the sequence needs well under a thousand cycles
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic check(input anpr_word_t seen, input anpr_word_t exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic reg_write(input anpr_addr_t a, input anpr_word_t d);
        @(negedge sys_clk_i);
        {addr, wdata, wr} = {a, d, 1'b1};
        @(negedge sys_clk_i);
        wr = 1'b0;
    endtask : reg_write

    // answer stands for exactly the cycle after the read edge
    task automatic reg_read(input anpr_addr_t a, input anpr_word_t exp);
        @(negedge sys_clk_i);
        {addr, rd} = {a, 1'b1};
        @(negedge sys_clk_i);
        rd = 1'b0;
        check({15'h0, rvalid}, 16'h0001);
        check(rdata, exp);
    endtask : reg_read

    initial begin
        repeat (6) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        rst_i = 1'b0;
        reg_read(`ANPR_REG_PARTNER, 16'h0000);
        reg_read(`ANPR_REG_EXPANSION, 16'h0004);
        reg_read(`ANPR_REG_TRANSMIT, 16'h0000);
        reg_read(5'h1f, 16'h0000);
        reg_write(`ANPR_REG_EXPANSION, 16'h0000);
        reg_read(`ANPR_REG_EXPANSION, 16'h0004);
        foreach (pages[i]) begin
            lp.send_page(pages[i]);
            check({15'h0, arrived}, 16'h0001);
            reg_read(`ANPR_REG_PARTNER, pages[i]);
            reg_read(`ANPR_REG_PARTNER, pages[i]);
            reg_read(`ANPR_REG_EXPANSION, 16'h0006);
            reg_read(`ANPR_REG_EXPANSION, 16'h0004);
        end
        reg_write(`ANPR_REG_PARTNER, 16'h1234);
        reg_read(`ANPR_REG_PARTNER, 16'ha5a5);
        lp.tech_burst(3'h4);
        check({15'h0, fault}, 16'h0000);
        lp.tech_burst(3'h3);
        check({15'h0, fault}, 16'h0001);
        reg_read(`ANPR_REG_EXPANSION, 16'h0014);
        reg_read(`ANPR_REG_EXPANSION, 16'h0004);
        lp.levels(1'b1, 1'b1, 1'b0);
        reg_read(`ANPR_REG_EXPANSION, 16'h000d);
        // extra pages were advertised before this exchange
        lp.base_done(1'b0);
        reg_write(`ANPR_REG_TRANSMIT, 16'hffff);
        check({15'h0, ready}, 16'h0001);
        check(tx_word, 16'hbfff);
        reg_read(`ANPR_REG_TRANSMIT, 16'hbfff);
        lp.levels(1'b0, 1'b0, 1'b1);
        reg_read(`ANPR_REG_TRANSMIT, 16'hffff);
        lp.page_sent();
        check({15'h0, ready}, 16'h0000);
        reg_read(`ANPR_REG_TRANSMIT, 16'hf7ff);
        lp.page_sent();
        reg_read(`ANPR_REG_TRANSMIT, 16'hffff);
        reg_write(`ANPR_REG_TRANSMIT, 16'h0000);
        reg_read(`ANPR_REG_TRANSMIT, 16'h4800);
        lp.base_done(1'b1);
        reg_read(`ANPR_REG_TRANSMIT, 16'h4000);
        reg_write(`ANPR_REG_TRANSMIT, 16'h07ff);
        check(tx_word, 16'h47ff);
        end_of_test();
    end
endmodule : anpr_regs_test
